/* File: core/csb_exec.sv */
// Execution unit for compares, skips, relative branches, I/O bits, shifts
//
// Overview of operation
// - Immediate compare sets flags, no write, one cycle
// - Register bit clear skips next instruction
// - Register bit set skips next instruction
// - I/O bit clear skips next instruction
// - I/O bit set skips next instruction
// - Flag clear branch jumps k plus one
// - Flag set branch jumps when flag one
// - Equal and not-equal test zero flag
// - Carry, lower, same-or-higher test carry
// - Minus and plus test negative flag
// - Signed branches test negative xor overflow
// - Half-carry branches test half-carry flag
// - Transfer branches test T flag
// - Overflow branches test V flag
// - Interrupt branches test global enable flag
// - Set I/O bit, two cycles, flags kept
// - Clear I/O bit, two cycles, flags kept
// - Left shift inserts zero, updates flags
// - Right shift inserts zero into bit 7
// - Rotate left moves carry in, bit 7 out
`timescale 1ns/1ps
module csb_exec
  import csb_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire csb_cmd_t cmd_i,
  output logic cmd_ready_o,
  output logic done_o,
  input wire logic [DATA_W-1:0] io_rd_data_i,
  output logic [IO_AW-1:0] io_rd_addr_o,
  output csb_io_wr_t io_wr_o,
  output csb_wb_t wb_o,
  input wire logic pc_load_i,
  input wire logic [PC_W-1:0] pc_load_val_i,
  output logic [PC_W-1:0] pc_o,
  input wire logic flags_load_i,
  input wire logic [DATA_W-1:0] flags_load_val_i,
  output logic [DATA_W-1:0] flags_o
);
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_STALL
  } csb_state_t;

  csb_state_t state_reg;
  logic [1:0] stall_cnt_reg;
  logic [PC_W-1:0] pc_reg;
  logic [DATA_W-1:0] flags_reg;
  logic done_reg;
  csb_io_wr_t io_wr_reg;
  csb_wb_t wb_reg;

  logic accept;
  logic idle;
  csb_br_t br;
  logic br_flag;
  logic br_taken;
  logic skip_hit;
  logic skip_bit;
  logic skip_want;
  logic skip_taken;
  logic alu_op;
  logic shift_op;
  logic io_bit_op;
  logic [DATA_W-1:0] alu_b;
  logic [DATA_W-1:0] alu_res;
  logic [DATA_W-1:0] alu_flags;
  logic [DATA_W-1:0] bit_mask;
  logic [PC_W-1:0] ofs_ext;
  logic [PC_W-1:0] pc_exec;
  logic [1:0] extra;

  // -------------------------------------------------------------
  // Handshake
  // -------------------------------------------------------------
  // Loads from the fetch path win over new commands, but are ignored while an op is in ST_STALL
  assign idle = (state_reg == ST_IDLE);
  assign cmd_ready_o = idle & ~pc_load_i & ~flags_load_i;
  assign accept = cmd_valid_i & cmd_ready_o;
  assign io_rd_addr_o = cmd_i.io_addr;
  assign done_o = done_reg;
  assign pc_o = pc_reg;
  assign flags_o = flags_reg;
  assign io_wr_o = io_wr_reg;
  assign wb_o = wb_reg;

  // -------------------------------------------------------------
  // Condition decode
  // -------------------------------------------------------------
  assign br = csb_branch_decode(cmd_i.op, cmd_i.bit_sel);
  assign br_flag = br.signed_test ? (flags_reg[FLAG_N] ^ flags_reg[FLAG_V])
                                  : flags_reg[br.idx];
  assign br_taken = br.hit & (br_flag == br.want);

  always_comb
  begin
    skip_hit = 1'b1;
    skip_bit = cmd_i.dst[cmd_i.bit_sel];
    skip_want = 1'b0;
    unique case (cmd_i.op)
      OP_SKIP_REG_BIT_CLEAR: skip_want = 1'b0;
      OP_SKIP_REG_BIT_SET: skip_want = 1'b1;
      OP_SKIP_IO_BIT_CLEAR:
      begin
        skip_bit = io_rd_data_i[cmd_i.bit_sel];
        skip_want = 1'b0;
      end
      OP_SKIP_IO_BIT_SET:
      begin
        skip_bit = io_rd_data_i[cmd_i.bit_sel];
        skip_want = 1'b1;
      end
      default: skip_hit = 1'b0;
    endcase
  end
  assign skip_taken = skip_hit & (skip_bit == skip_want);

  assign io_bit_op = (cmd_i.op == OP_SET_IO_BIT) | (cmd_i.op == OP_CLEAR_IO_BIT);
  assign shift_op = (cmd_i.op == OP_LOGICAL_SHIFT_LEFT)
                    | (cmd_i.op == OP_LOGICAL_SHIFT_RIGHT)
                    | (cmd_i.op == OP_ROTATE_LEFT_CARRY);
  assign alu_op = shift_op | (cmd_i.op == OP_COMPARE_IMMEDIATE)
                  | (cmd_i.op == OP_COMPARE_WITH_CARRY);
  assign alu_b = (cmd_i.op == OP_COMPARE_IMMEDIATE) ? cmd_i.imm : cmd_i.src;
  assign bit_mask = BIT_ONE << cmd_i.bit_sel;
  assign ofs_ext = {{(PC_W-OFS_W){cmd_i.ofs[OFS_W-1]}}, cmd_i.ofs};

  // -------------------------------------------------------------
  // Arithmetic and shifts
  // -------------------------------------------------------------
  csb_alu u_alu (
    .op_i(cmd_i.op),
    .a_i(cmd_i.dst),
    .b_i(alu_b),
    .flags_i(flags_reg),
    .res_o(alu_res),
    .flags_o(alu_flags)
  );

  // -------------------------------------------------------------
  // Next program counter and cost
  // -------------------------------------------------------------
  always_comb
  begin
    pc_exec = pc_reg + PC_STEP;
    extra = EXTRA_NONE;
    if (skip_taken)
    begin
      pc_exec = pc_reg + (cmd_i.next_two_word ? PC_SKIP_TWO : PC_SKIP_ONE);
      extra = cmd_i.next_two_word ? EXTRA_TWO : EXTRA_ONE;
    end
    else if (br_taken)
    begin
      pc_exec = pc_reg + ofs_ext + PC_STEP;
      extra = EXTRA_ONE;
    end
    else if (io_bit_op)
    begin
      extra = EXTRA_ONE;
    end
  end

  // -------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= ST_IDLE;
      stall_cnt_reg <= EXTRA_NONE;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE:
        begin
          if (accept && extra == EXTRA_NONE)
          begin
            done_reg <= 1'b1;
          end
          else if (accept)
          begin
            state_reg <= ST_STALL;
            stall_cnt_reg <= extra - EXTRA_ONE;
          end
        end
        ST_STALL:
        begin
          if (stall_cnt_reg == EXTRA_NONE)
          begin
            state_reg <= ST_IDLE;
            done_reg <= 1'b1;
          end
          else
          begin
            stall_cnt_reg <= stall_cnt_reg - EXTRA_ONE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pc_reg <= PC_RESET;
    end
    else if (idle && pc_load_i)
    begin
      pc_reg <= pc_load_val_i;
    end
    else if (accept)
    begin
      pc_reg <= pc_exec;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      flags_reg <= FLAGS_RESET;
    end
    else if (idle && flags_load_i)
    begin
      flags_reg <= flags_load_val_i;
    end
    else if (accept && alu_op)
    begin
      flags_reg <= alu_flags;
    end
  end

  // -------------------------------------------------------------
  // Write paths
  // -------------------------------------------------------------
  // Read-modify-write keeps the other bits of the port
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      io_wr_reg <= '0;
    end
    else if (accept && io_bit_op)
    begin
      io_wr_reg.we <= 1'b1;
      io_wr_reg.addr <= cmd_i.io_addr;
      io_wr_reg.data <= (cmd_i.op == OP_SET_IO_BIT) ? (io_rd_data_i | bit_mask)
                                                     : (io_rd_data_i & ~bit_mask);
    end
    else
    begin
      io_wr_reg.we <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wb_reg <= '0;
    end
    else if (accept && shift_op)
    begin
      wb_reg.we <= 1'b1;
      wb_reg.idx <= cmd_i.dst_idx;
      wb_reg.data <= alu_res;
    end
    else
    begin
      wb_reg.we <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  csb_cmd_t acc_cmd_reg;
  logic [PC_W-1:0] acc_pc_reg;
  logic [DATA_W-1:0] acc_flags_reg;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      acc_cmd_reg <= '0;
      acc_pc_reg <= PC_RESET;
      acc_flags_reg <= FLAGS_RESET;
    end
    else if (accept)
    begin
      acc_cmd_reg <= cmd_i;
      acc_pc_reg <= pc_reg;
      acc_flags_reg <= flags_reg;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_CMP_IMM: assert property (
    accept && cmd_i.op == OP_COMPARE_IMMEDIATE
    |=> done_o && !wb_o.we && flags_o[FLAG_Z] == (acc_cmd_reg.dst == acc_cmd_reg.imm)
        && flags_o[FLAG_C] == (acc_cmd_reg.dst < acc_cmd_reg.imm))
    else $error("immediate compare flags or timing wrong");

  AST_CMP_CARRY: assert property (
    accept && cmd_i.op == OP_COMPARE_WITH_CARRY
    |=> done_o && !wb_o.we && flags_o[FLAG_C] == ({1'b0, acc_cmd_reg.dst}
        < ({1'b0, acc_cmd_reg.src} + {8'h00, acc_flags_reg[FLAG_C]})))
    else $error("carry compare borrow wrong");

  AST_SKIP_REG_ONE: assert property (
    accept && cmd_i.op == OP_SKIP_REG_BIT_CLEAR && !cmd_i.dst[cmd_i.bit_sel]
    && !cmd_i.next_two_word
    |=> !done_o && !cmd_ready_o ##1 done_o && pc_o == acc_pc_reg + PC_SKIP_ONE)
    else $error("register clear skip wrong");

  AST_SKIP_REG_SET_NOT: assert property (
    accept && cmd_i.op == OP_SKIP_REG_BIT_SET && !cmd_i.dst[cmd_i.bit_sel]
    |=> done_o && pc_o == acc_pc_reg + PC_STEP)
    else $error("register set skip taken on zero");

  AST_SKIP_IO: assert property (
    accept && cmd_i.op == OP_SKIP_IO_BIT_SET && io_rd_data_i[cmd_i.bit_sel]
    |=> !done_o)
    else $error("I/O set skip not taken");

  AST_SKIP_TWO_WORD: assert property (
    accept && skip_taken && cmd_i.next_two_word
    |=> !done_o [*2] ##1 done_o && pc_o == acc_pc_reg + PC_SKIP_TWO)
    else $error("two-word skip wrong");

  AST_BRANCH_TAKEN: assert property (
    accept && cmd_i.op == OP_BRANCH_FLAG_CLEAR && !flags_reg[cmd_i.bit_sel]
    |=> !done_o ##1 done_o
        && pc_o == acc_pc_reg + {{(PC_W-OFS_W){acc_cmd_reg.ofs[OFS_W-1]}},
                                 acc_cmd_reg.ofs} + PC_STEP)
    else $error("flag clear branch target or timing wrong");

  AST_BRANCH_EQUAL_NOT: assert property (
    accept && cmd_i.op == OP_BRANCH_EQUAL && !flags_reg[FLAG_Z]
    |=> done_o && pc_o == acc_pc_reg + PC_STEP)
    else $error("equal branch taken with zero clear");

  AST_BRANCH_SIGNED: assert property (
    accept && cmd_i.op == OP_BRANCH_SIGNED_GE
    && (flags_reg[FLAG_N] ^ flags_reg[FLAG_V])
    |=> done_o)
    else $error("signed ge taken on less");

  AST_IO_SET: assert property (
    accept && cmd_i.op == OP_SET_IO_BIT
    |=> io_wr_o.we && io_wr_o.data[acc_cmd_reg.bit_sel] && !done_o
        && flags_o == acc_flags_reg ##1 done_o && !io_wr_o.we)
    else $error("I/O set bit wrong");

  AST_IO_CLEAR: assert property (
    accept && cmd_i.op == OP_CLEAR_IO_BIT
    |=> io_wr_o.we && !io_wr_o.data[acc_cmd_reg.bit_sel]
        && (io_wr_o.data | (BIT_ONE << acc_cmd_reg.bit_sel))
           == ($past(io_rd_data_i) | (BIT_ONE << acc_cmd_reg.bit_sel)))
    else $error("I/O clear bit disturbed other bits");

  AST_SHIFT_LEFT: assert property (
    accept && cmd_i.op == OP_LOGICAL_SHIFT_LEFT
    |=> wb_o.we && done_o && wb_o.data == {acc_cmd_reg.dst[MSB-1:LSB], 1'b0}
        && flags_o[FLAG_C] == acc_cmd_reg.dst[MSB])
    else $error("left shift wrong");

  AST_SHIFT_RIGHT: assert property (
    accept && cmd_i.op == OP_LOGICAL_SHIFT_RIGHT
    |=> wb_o.we && wb_o.data == {1'b0, acc_cmd_reg.dst[MSB:LSB+1]})
    else $error("right shift wrong");

  AST_ROTATE: assert property (
    accept && cmd_i.op == OP_ROTATE_LEFT_CARRY
    |=> wb_o.data == {acc_cmd_reg.dst[MSB-1:LSB], acc_flags_reg[FLAG_C]}
        && flags_o[FLAG_C] == acc_cmd_reg.dst[MSB])
    else $error("rotate through carry wrong");

  COV_COMPARE: cover property (accept && cmd_i.op == OP_COMPARE_IMMEDIATE);
  COV_SKIP_TWO: cover property (accept && skip_taken && cmd_i.next_two_word);
  COV_BRANCH: cover property (accept && br_taken);
  COV_IO_BIT: cover property (accept && io_bit_op ##2 done_o);
endmodule : csb_exec

/* File: core/csb_pkg.sv */
// Shared types and constants of the compare, skip, branch and shift unit
package csb_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 16;
  localparam int OFS_W = 7;
  localparam int IO_AW = 6;
  localparam int REG_AW = 5;
  localparam int BIT_W = 3;
  localparam int MSB = 7;
  localparam int HALF_BIT = 3;
  localparam int LSB = 0;

  // -------------------------------------------------------------
  // Status flag positions
  // -------------------------------------------------------------
  localparam logic [BIT_W-1:0] FLAG_C = 3'h0;
  localparam logic [BIT_W-1:0] FLAG_Z = 3'h1;
  localparam logic [BIT_W-1:0] FLAG_N = 3'h2;
  localparam logic [BIT_W-1:0] FLAG_V = 3'h3;
  localparam logic [BIT_W-1:0] FLAG_S = 3'h4;
  localparam logic [BIT_W-1:0] FLAG_H = 3'h5;
  localparam logic [BIT_W-1:0] FLAG_T = 3'h6;
  localparam logic [BIT_W-1:0] FLAG_I = 3'h7;

  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
  localparam logic [PC_W-1:0] PC_SKIP_ONE = 16'h0002;
  localparam logic [PC_W-1:0] PC_SKIP_TWO = 16'h0003;
  localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_ONE = 2'h1;
  localparam logic [1:0] EXTRA_TWO = 2'h2;

  typedef enum logic [5:0] {
    OP_NOP,
    OP_COMPARE_IMMEDIATE,
    OP_COMPARE_WITH_CARRY,
    OP_SKIP_REG_BIT_CLEAR,
    OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET,
    OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_EQUAL,
    OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_SET,
    OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_SAME_OR_HIGHER,
    OP_BRANCH_LOWER,
    OP_BRANCH_MINUS,
    OP_BRANCH_PLUS,
    OP_BRANCH_SIGNED_GE,
    OP_BRANCH_SIGNED_LESS,
    OP_BRANCH_HALF_CARRY_SET,
    OP_BRANCH_HALF_CARRY_CLEAR,
    OP_BRANCH_TRANSFER_FLAG_SET,
    OP_BRANCH_TRANSFER_FLAG_CLEAR,
    OP_BRANCH_OVERFLOW_SET,
    OP_BRANCH_OVERFLOW_CLEAR,
    OP_BRANCH_IRQ_ENABLED,
    OP_BRANCH_IRQ_DISABLED,
    OP_SET_IO_BIT,
    OP_CLEAR_IO_BIT,
    OP_LOGICAL_SHIFT_LEFT,
    OP_LOGICAL_SHIFT_RIGHT,
    OP_ROTATE_LEFT_CARRY
  } csb_op_t;

  typedef struct packed {
    csb_op_t op;
    logic [DATA_W-1:0] dst;
    logic [DATA_W-1:0] src;
    logic [DATA_W-1:0] imm;
    logic [BIT_W-1:0] bit_sel;
    logic [OFS_W-1:0] ofs;
    logic [IO_AW-1:0] io_addr;
    logic [REG_AW-1:0] dst_idx;
    logic next_two_word;
  } csb_cmd_t;

  typedef struct packed {
    logic we;
    logic [IO_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } csb_io_wr_t;

  typedef struct packed {
    logic we;
    logic [REG_AW-1:0] idx;
    logic [DATA_W-1:0] data;
  } csb_wb_t;

  typedef struct packed {
    logic hit;
    logic [BIT_W-1:0] idx;
    logic want;
    logic signed_test;
  } csb_br_t;

  // Maps every conditional branch onto flag index and wanted level
  function automatic csb_br_t csb_branch_decode(csb_op_t op, logic [BIT_W-1:0] s);
    csb_br_t r;
    r = '{hit: 1'b1, idx: s, want: 1'b1, signed_test: 1'b0};
    unique case (op)
      OP_BRANCH_FLAG_SET: r.want = 1'b1;
      OP_BRANCH_FLAG_CLEAR: r.want = 1'b0;
      OP_BRANCH_EQUAL: r = '{1'b1, FLAG_Z, 1'b1, 1'b0};
      OP_BRANCH_NOT_EQUAL: r = '{1'b1, FLAG_Z, 1'b0, 1'b0};
      OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: r = '{1'b1, FLAG_C, 1'b1, 1'b0};
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: r = '{1'b1, FLAG_C, 1'b0, 1'b0};
      OP_BRANCH_MINUS: r = '{1'b1, FLAG_N, 1'b1, 1'b0};
      OP_BRANCH_PLUS: r = '{1'b1, FLAG_N, 1'b0, 1'b0};
      OP_BRANCH_SIGNED_GE: r = '{1'b1, FLAG_S, 1'b0, 1'b1};
      OP_BRANCH_SIGNED_LESS: r = '{1'b1, FLAG_S, 1'b1, 1'b1};
      OP_BRANCH_HALF_CARRY_SET: r = '{1'b1, FLAG_H, 1'b1, 1'b0};
      OP_BRANCH_HALF_CARRY_CLEAR: r = '{1'b1, FLAG_H, 1'b0, 1'b0};
      OP_BRANCH_TRANSFER_FLAG_SET: r = '{1'b1, FLAG_T, 1'b1, 1'b0};
      OP_BRANCH_TRANSFER_FLAG_CLEAR: r = '{1'b1, FLAG_T, 1'b0, 1'b0};
      OP_BRANCH_OVERFLOW_SET: r = '{1'b1, FLAG_V, 1'b1, 1'b0};
      OP_BRANCH_OVERFLOW_CLEAR: r = '{1'b1, FLAG_V, 1'b0, 1'b0};
      OP_BRANCH_IRQ_ENABLED: r = '{1'b1, FLAG_I, 1'b1, 1'b0};
      OP_BRANCH_IRQ_DISABLED: r = '{1'b1, FLAG_I, 1'b0, 1'b0};
      default: r.hit = 1'b0;
    endcase
    return r;
  endfunction : csb_branch_decode
endpackage : csb_pkg

/* File: core/csb_alu.sv */
// Flag and result logic for compares and single-bit shifts
`timescale 1ns/1ps
module csb_alu
  import csb_pkg::*;
(
  input wire csb_op_t op_i,
  input wire logic [DATA_W-1:0] a_i,
  input wire logic [DATA_W-1:0] b_i,
  input wire logic [DATA_W-1:0] flags_i,
  output logic [DATA_W-1:0] res_o,
  output logic [DATA_W-1:0] flags_o
);
  logic cin;
  logic [DATA_W-1:0] diff;
  logic is_shift;

  always_comb
  begin
    res_o = a_i;
    flags_o = flags_i;
    is_shift = 1'b0;
    cin = (op_i == OP_COMPARE_WITH_CARRY) & flags_i[FLAG_C];
    diff = a_i - b_i - {7'h00, cin};
    unique case (op_i)
      OP_COMPARE_IMMEDIATE, OP_COMPARE_WITH_CARRY:
      begin
        res_o = diff;
        flags_o[FLAG_H] = (~a_i[HALF_BIT] & b_i[HALF_BIT]) | (b_i[HALF_BIT] & diff[HALF_BIT])
                          | (diff[HALF_BIT] & ~a_i[HALF_BIT]);
        flags_o[FLAG_V] = (a_i[MSB] & ~b_i[MSB] & ~diff[MSB])
                          | (~a_i[MSB] & b_i[MSB] & diff[MSB]);
        flags_o[FLAG_C] = (~a_i[MSB] & b_i[MSB]) | (b_i[MSB] & diff[MSB])
                          | (diff[MSB] & ~a_i[MSB]);
        flags_o[FLAG_N] = diff[MSB];
        // Carry form keeps a zero chain across multi-byte compares
        flags_o[FLAG_Z] = (diff == ZERO_BYTE)
                          & ((op_i == OP_COMPARE_IMMEDIATE) | flags_i[FLAG_Z]);
        flags_o[FLAG_S] = flags_o[FLAG_N] ^ flags_o[FLAG_V];
      end
      OP_LOGICAL_SHIFT_LEFT:
      begin
        is_shift = 1'b1;
        res_o = {a_i[MSB-1:LSB], 1'b0};
        flags_o[FLAG_C] = a_i[MSB];
      end
      OP_LOGICAL_SHIFT_RIGHT:
      begin
        is_shift = 1'b1;
        res_o = {1'b0, a_i[MSB:LSB+1]};
        flags_o[FLAG_C] = a_i[LSB];
      end
      OP_ROTATE_LEFT_CARRY:
      begin
        is_shift = 1'b1;
        res_o = {a_i[MSB-1:LSB], flags_i[FLAG_C]};
        flags_o[FLAG_C] = a_i[MSB];
      end
      default:
      begin
        is_shift = 1'b0;
      end
    endcase
    if (is_shift)
    begin
      flags_o[FLAG_N] = res_o[MSB];
      flags_o[FLAG_Z] = (res_o == ZERO_BYTE);
      flags_o[FLAG_V] = res_o[MSB] ^ flags_o[FLAG_C];
      flags_o[FLAG_S] = flags_o[FLAG_N] ^ flags_o[FLAG_V];
    end
  end
endmodule : csb_alu

/* File: verification/compare_skip_branch_shift_exec_test.sv */
// Self-checking bench for the compare, skip, branch and shift unit
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module compare_skip_branch_shift_exec_test;
  import csb_pkg::*;
  typedef struct {
    csb_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic [2:0] s;
    logic tw;
    logic [7:0] fl;
    logic [7:0] io;
    logic [15:0] pc;
    logic [7:0] efl;
    int cyc;
    logic [7:0] res;
  } csb_tb_row_t;
  logic clk_i, nrst_i, cmd_valid_i, pc_load_i, flags_load_i, cmd_ready_o, done_o;
  csb_cmd_t cmd_i;
  logic [7:0] io_rd_data_i, flags_load_val_i, flags_o;
  logic [5:0] io_rd_addr_o;
  csb_io_wr_t io_wr_o;
  csb_wb_t wb_o;
  logic [15:0] pc_load_val_i, pc_o;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Ops 7..26 in order: bit 4 wanted level, low nibble flag, 8 general, 9 signed
  logic [7:0] codes [20] = '{8'h18, 8'h08, 8'h11, 8'h01, 8'h10, 8'h00, 8'h00, 8'h10,
    8'h12, 8'h02, 8'h09, 8'h19, 8'h15, 8'h05, 8'h16, 8'h06, 8'h13, 8'h03, 8'h17, 8'h07};
  logic [7:0] pats [4] = '{8'h00, 8'hFF, 8'h04, 8'h08};
  logic [6:0] ks [3] = '{7'h7F, 7'h3F, 7'h40};
  csb_tb_row_t rows [21] = '{
    '{OP_COMPARE_IMMEDIATE, 8'h10, 8'h01, 3'h0, 1'h0, 8'h00, 8'h00, 16'h0101, 8'h20, 1, 8'h00},
    '{OP_COMPARE_IMMEDIATE, 8'h80, 8'h80, 3'h0, 1'h0, 8'h00, 8'h00, 16'h0101, 8'h02, 1, 8'h00},
    '{OP_COMPARE_IMMEDIATE, 8'h80, 8'h01, 3'h0, 1'h0, 8'hD0, 8'h00, 16'h0101, 8'hF8, 1, 8'h00},
    '{OP_COMPARE_WITH_CARRY, 8'h00, 8'h00, 3'h0, 1'h0, 8'h03, 8'h00, 16'h0101, 8'h35, 1, 8'h00},
    '{OP_COMPARE_WITH_CARRY, 8'h05, 8'h05, 3'h0, 1'h0, 8'h00, 8'h00, 16'h0101, 8'h00, 1, 8'h00},
    '{OP_COMPARE_WITH_CARRY, 8'h05, 8'h05, 3'h0, 1'h0, 8'h02, 8'h00, 16'h0101, 8'h02, 1, 8'h00},
    '{OP_SKIP_REG_BIT_CLEAR, 8'hFB, 8'h00, 3'h2, 1'h0, 8'h00, 8'h00, 16'h0102, 8'h00, 2, 8'h00},
    '{OP_SKIP_REG_BIT_CLEAR, 8'h04, 8'h00, 3'h2, 1'h1, 8'h00, 8'h00, 16'h0101, 8'h00, 1, 8'h00},
    '{OP_SKIP_REG_BIT_SET, 8'h80, 8'h00, 3'h7, 1'h1, 8'h00, 8'h00, 16'h0103, 8'h00, 3, 8'h00},
    '{OP_SKIP_REG_BIT_SET, 8'h7F, 8'h00, 3'h7, 1'h0, 8'h00, 8'h00, 16'h0101, 8'h00, 1, 8'h00},
    '{OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h00, 3'h0, 1'h1, 8'h00, 8'hFE, 16'h0103, 8'h00, 3, 8'h00},
    '{OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 3'h0, 1'h0, 8'h00, 8'h01, 16'h0102, 8'h00, 2, 8'h00},
    '{OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 3'h0, 1'h0, 8'h00, 8'hFE, 16'h0101, 8'h00, 1, 8'h00},
    '{OP_SET_IO_BIT, 8'h00, 8'h00, 3'h0, 1'h0, 8'hA5, 8'h5A, 16'h0101, 8'hA5, 2, 8'h5B},
    '{OP_CLEAR_IO_BIT, 8'h00, 8'h00, 3'h1, 1'h0, 8'h5A, 8'h5A, 16'h0101, 8'h5A, 2, 8'h58},
    '{OP_LOGICAL_SHIFT_LEFT, 8'h81, 8'h00, 3'h0, 1'h0, 8'h20, 8'h00, 16'h0101, 8'h39, 1, 8'h02},
    '{OP_LOGICAL_SHIFT_LEFT, 8'h80, 8'h00, 3'h0, 1'h0, 8'h00, 8'h00, 16'h0101, 8'h1B, 1, 8'h00},
    '{OP_LOGICAL_SHIFT_RIGHT, 8'h01, 8'h00, 3'h0, 1'h0, 8'h00, 8'h00, 16'h0101, 8'h1B, 1, 8'h00},
    '{OP_LOGICAL_SHIFT_RIGHT, 8'h80, 8'h00, 3'h0, 1'h0, 8'h3F, 8'h00, 16'h0101, 8'h20, 1, 8'h40},
    '{OP_ROTATE_LEFT_CARRY, 8'h80, 8'h00, 3'h0, 1'h0, 8'h01, 8'h00, 16'h0101, 8'h19, 1, 8'h01},
    '{OP_ROTATE_LEFT_CARRY, 8'h40, 8'h00, 3'h0, 1'h0, 8'h00, 8'h00, 16'h0101, 8'h0C, 1, 8'h80}};

  csb_exec dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .io_rd_data_i(io_rd_data_i),
    .io_rd_addr_o(io_rd_addr_o), .io_wr_o(io_wr_o), .wb_o(wb_o), .pc_load_i(pc_load_i),
    .pc_load_val_i(pc_load_val_i), .pc_o(pc_o), .flags_load_i(flags_load_i),
    .flags_load_val_i(flags_load_val_i), .flags_o(flags_o)
  );

  // ---------------------------------------------
  // Clock, watchdog, closing report
  // ---------------------------------------------
  initial
  begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  // Whole run needs about 360 cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // ---------------------------------------------
  // One command from a fixed start point 0x0100
  // ---------------------------------------------
  task automatic run(input csb_tb_row_t r, input logic [6:0] k);
    int n;
    logic [7:0] res;
    n = 0;
    res = 8'h00;
    @(posedge clk_i);
    pc_load_i <= 1'h1;
    pc_load_val_i <= 16'h0100;
    flags_load_i <= 1'h1;
    flags_load_val_i <= r.fl;
    @(posedge clk_i);
    pc_load_i <= 1'h0;
    flags_load_i <= 1'h0;
    cmd_valid_i <= 1'h1;
    cmd_i <= '{r.op, r.a, r.b, r.b, r.s, k, 6'h2A, 5'h11, r.tw};
    io_rd_data_i <= r.io;
    @(posedge clk_i);
    cmd_valid_i <= 1'h0;
    // First look is just after the accept edge, where one-cycle ops finish
    forever
    begin
      #1;
      n++;
      if (wb_o.we) res = wb_o.data;
      if (wb_o.we) `CHK(wb_o.idx, 5'h11)
      if (io_wr_o.we) res = io_wr_o.data;
      if (io_wr_o.we) `CHK(io_wr_o.addr, 6'h2A)
      if (done_o === 1'h1 || n >= 8) break;
      `CHK(cmd_ready_o, 1'h0)
      @(posedge clk_i);
    end
    `CHK(n, r.cyc)
    `CHK(pc_o, r.pc)
    `CHK(flags_o, r.efl)
    `CHK(res, r.res)
    `CHK(io_rd_addr_o, 6'h2A)
  endtask : run

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial
  begin
    csb_tb_row_t r;
    logic [7:0] c;
    logic bit_v;
    nrst_i = 1'h0;
    cmd_valid_i = 1'h0;
    cmd_i = '0;
    io_rd_data_i = 8'h00;
    pc_load_i = 1'h0;
    pc_load_val_i = 16'h0000;
    flags_load_i = 1'h0;
    flags_load_val_i = 8'h00;
    repeat (3) @(posedge clk_i);
    `CHK({pc_o, flags_o, done_o}, 25'h0)
    nrst_i <= 1'h1;
    foreach (rows[i]) run(rows[i], 7'h00);
    $display("table cases done");
    for (int i = 7; i <= 26; i++)
    begin
      for (int j = 0; j < 4; j++)
      begin
        c = codes[i-7];
        r = '{csb_op_t'(i), 8'h00, 8'h00, 3'(i + j), 1'h0, pats[j], 8'h00, 16'h0101,
          pats[j], 1, 8'h00};
        bit_v = (c[3:0] == 4'h8) ? r.fl[r.s] : (c[3:0] == 4'h9) ? (r.fl[2] ^ r.fl[3])
          : r.fl[c[2:0]];
        if (bit_v == c[4])
        begin
          r.pc = 16'h0101 + {{9{ks[j%3][6]}}, ks[j%3]};
          r.cyc = 2;
        end
        run(r, ks[j%3]);
      end
    end
    $display("branch cases done");
    // Pending loads refuse commands
    @(posedge clk_i);
    flags_load_i <= 1'h1;
    #1;
    `CHK(cmd_ready_o, 1'h0)
    @(posedge clk_i);
    flags_load_i <= 1'h0;
    pc_load_i <= 1'h1;
    pc_load_val_i <= 16'h0100;
    #1;
    `CHK(cmd_ready_o, 1'h0)
    // Back to back single-cycle shifts from the loaded 0x0100
    @(posedge clk_i);
    pc_load_i <= 1'h0;
    cmd_valid_i <= 1'h1;
    cmd_i <= '{OP_LOGICAL_SHIFT_LEFT, 8'h01, 8'h00, 8'h00, 3'h0, 7'h00, 6'h2A, 5'h11, 1'h0};
    @(posedge clk_i);
    cmd_i.op <= OP_LOGICAL_SHIFT_RIGHT;
    cmd_i.dst <= 8'h80;
    #1;
    `CHK({done_o, wb_o.data}, 9'h102)
    @(posedge clk_i);
    cmd_valid_i <= 1'h0;
    #1;
    `CHK({done_o, wb_o.data, pc_o}, 25'h1400102)
    $display("back to back done");
    // Reset in the middle of a three-cycle skip
    @(posedge clk_i);
    cmd_valid_i <= 1'h1;
    cmd_i <= '{OP_SKIP_REG_BIT_SET, 8'h80, 8'h00, 8'h00, 3'h7, 7'h00, 6'h2A, 5'h11, 1'h1};
    @(posedge clk_i);
    cmd_valid_i <= 1'h0;
    @(posedge clk_i);
    nrst_i <= 1'h0;
    #1;
    `CHK({pc_o, done_o, cmd_ready_o}, 18'h1)
    @(posedge clk_i);
    nrst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK({pc_o, done_o}, 17'h0)
    $display("reset case done");
    end_of_test();
  end
endmodule : compare_skip_branch_shift_exec_test
